/* design/dcu_core.sv */
// Purpose: serial write decode, buffer and active code registers, switch drive
// Assumes: frame select, serial clock, data and level select come from pins
// Notes:   all pins but reset_n pass two flip-flops; serial clock edges found by sampling

`timescale 1ns/1ps

module dcu_core (
   // clock and reset
   input  wire logic        clk,
   input  wire logic        reset_n,
   // serial port pins
   input  wire logic        frame_sel_n,
   input  wire logic        serial_clk,
   input  wire logic        serial_data_in,
   // reset level strap
   input  wire logic        reset_level_select,
   // converter switch drive
   output logic      [14:0] segment_switch_controls,
   output logic      [11:0] ladder_switch_controls,
   // status
   output logic      [15:0] active_code,
   output logic             defer_mode
);

   // ----------------------------------------------------------------------
   // state
   // ----------------------------------------------------------------------
   dcu_pkg::dcu_state_s st_q;
   dcu_pkg::dcu_state_s st_d;

   logic        sel_rise;
   logic        sel_fall;
   logic        clk_fall;
   logic        frame_ok;
   logic        wr_commit;
   logic [6:0]  wr_addr;
   logic [15:0] wr_data;
   logic [15:0] default_code;
   logic        init_load;
   logic        restart;
   logic [14:0] seg_dec;

   // ----------------------------------------------------------------------
   // edge detection on synchronised pins
   // ----------------------------------------------------------------------
   // only second sync stages are looked at; first stages may be metastable
   assign sel_rise  = st_q.sel_sync[1] & ~st_q.sel_last;
   assign sel_fall  = ~st_q.sel_sync[1] & st_q.sel_last;
   assign clk_fall  = ~st_q.clk_sync[1] & st_q.clk_last & ~st_q.sel_sync[1];
   assign frame_ok  = sel_rise & (st_q.edge_cnt >= dcu_pkg::FRAME_BITS);
   assign wr_addr   = st_q.shift[dcu_pkg::ADDR_HI:dcu_pkg::ADDR_LO];
   assign wr_data   = st_q.shift[dcu_pkg::CODE_W-1:0];
   assign wr_commit = frame_ok & (st_q.shift[dcu_pkg::RW_BIT] == dcu_pkg::WRITE_FLAG);
   assign init_load = (st_q.init_cnt == dcu_pkg::INIT_LOAD);
   assign restart   = wr_commit & (wr_addr == dcu_pkg::ADDR_STROBE)
                      & (wr_data[3:0] == dcu_pkg::RESTART_CODE);
   assign default_code = st_q.lvl_sync[1] ? dcu_pkg::CODE_MID
                                          : dcu_pkg::CODE_ZERO;

   // ----------------------------------------------------------------------
   // segment decode
   // ----------------------------------------------------------------------
   dcu_thermo u_thermo (
      .msb (st_q.active_code[15:12]),
      .seg (seg_dec)
   );

   // ----------------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------------
   always_comb begin
      st_d = st_q;
      st_d.sel_sync = {st_q.sel_sync[0], frame_sel_n};
      st_d.clk_sync = {st_q.clk_sync[0], serial_clk};
      st_d.dat_sync = {st_q.dat_sync[0], serial_data_in};
      st_d.lvl_sync = {st_q.lvl_sync[0], reset_level_select};
      st_d.sel_last = st_q.sel_sync[1];
      st_d.clk_last = st_q.clk_sync[1];
      st_d.segments = seg_dec;
      if (st_q.init_cnt != dcu_pkg::INIT_DONE) begin
         st_d.init_cnt = st_q.init_cnt + 2'h1;
      end

      // frame capture, msb first on falling serial clock
      if (sel_fall) begin
         st_d.edge_cnt = 5'h00;
         st_d.shift    = 24'h000000;
      end else if (clk_fall) begin
         st_d.shift = {st_q.shift[dcu_pkg::FRAME_W-2:0], st_q.dat_sync[1]};
         if (st_q.edge_cnt < dcu_pkg::FRAME_BITS) begin
            st_d.edge_cnt = st_q.edge_cnt + 5'h01;
         end
      end

      // select rise ends a frame: commit a full frame, drop a short one
      if (sel_rise) begin
         st_d.edge_cnt = 5'h00;
         st_d.shift    = 24'h000000;
      end

      if (wr_commit && !restart) begin
         case (wr_addr)
            dcu_pkg::ADDR_CODE: begin
               st_d.buffer_code = wr_data;
               if (!st_q.defer_en) begin
                  st_d.active_code = wr_data;
               end
            end
            dcu_pkg::ADDR_MODE: begin
               st_d.defer_en = wr_data[dcu_pkg::MODE_DEFER_BIT];
            end
            dcu_pkg::ADDR_STROBE: begin
               // trigger is never stored, so it is clear after the load
               if (wr_data[dcu_pkg::STROBE_LOAD_BIT] && st_q.defer_en) begin
                  st_d.active_code = st_q.buffer_code;
               end
            end
            default: begin
               st_d.defer_en = st_q.defer_en;
            end
         endcase
      end

      // defaults after reset release or a restart write; the strap is
      // sampled here because an async reset may only load constants
      if (init_load || restart) begin
         st_d.buffer_code = default_code;
         st_d.active_code = default_code;
         st_d.defer_en    = dcu_pkg::MODE_RESET;
      end
   end

   // ----------------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------------
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         st_q.sel_sync    <= 2'h3;
         // edge detectors start at the pins' idle levels, so no false edge follows reset
         st_q.clk_sync    <= 2'h3;
         st_q.dat_sync    <= 2'h0;
         st_q.lvl_sync    <= 2'h0;
         st_q.sel_last    <= 1'b1;
         st_q.clk_last    <= 1'b1;
         st_q.init_cnt    <= 2'h0;
         st_q.edge_cnt    <= 5'h00;
         st_q.shift       <= 24'h000000;
         st_q.buffer_code <= dcu_pkg::CODE_ZERO;
         st_q.active_code <= dcu_pkg::CODE_ZERO;
         st_q.defer_en    <= dcu_pkg::MODE_RESET;
         st_q.segments    <= 15'h0000;
      end else begin
         st_q <= st_d;
      end
   end

   // ----------------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------------
   assign segment_switch_controls = st_q.segments;
   assign ladder_switch_controls  = st_q.active_code[dcu_pkg::LADDER_W-1:0];
   assign active_code             = st_q.active_code;
   assign defer_mode              = st_q.defer_en;

   // ----------------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);

   sequence s_code_write;
      wr_commit && !restart && (wr_addr == dcu_pkg::ADDR_CODE) && !init_load;
   endsequence

   sequence s_load_write;
      wr_commit && !restart && (wr_addr == dcu_pkg::ADDR_STROBE)
         && wr_data[dcu_pkg::STROBE_LOAD_BIT] && !init_load;
   endsequence

   sequence s_short_frame;
      sel_rise && (st_q.edge_cnt < dcu_pkg::FRAME_BITS) && !init_load;
   endsequence

   AST_BUF_CAPTURE: assert property (
      s_code_write |=> st_q.buffer_code == $past(wr_data))
      else $error("code write not captured in buffer");

   AST_IMMEDIATE: assert property (
      s_code_write ##0 !st_q.defer_en |=> st_q.active_code == $past(wr_data))
      else $error("immediate mode did not update active code");

   AST_IMMEDIATE_PIN: assert property (
      s_code_write ##0 !st_q.defer_en |=> ##1
         ladder_switch_controls == $past(wr_data[11:0], 2))
      else $error("ladder drive did not follow immediate write");

   AST_DEFER_HOLD: assert property (
      s_code_write ##0 st_q.defer_en |=> $stable(st_q.active_code))
      else $error("deferred mode write changed active code");

   AST_LOAD: assert property (
      s_load_write ##0 st_q.defer_en |=> st_q.active_code == $past(st_q.buffer_code))
      else $error("load trigger did not copy buffer");

   AST_LOAD_IGNORED: assert property (
      s_load_write ##0 !st_q.defer_en |=> $stable(st_q.active_code))
      else $error("load trigger acted in immediate mode");

   AST_MODE: assert property (
      wr_commit && !restart && !init_load && (wr_addr == dcu_pkg::ADDR_MODE)
         |=> st_q.defer_en == $past(wr_data[0]))
      else $error("mode bit not written");

   AST_SHORT_FRAME: assert property (
      s_short_frame |=> $stable(st_q.active_code) && $stable(st_q.buffer_code)
         && $stable(st_q.defer_en) && (st_q.shift == 24'h000000))
      else $error("short frame was not discarded");

   AST_RESTART: assert property (
      restart |=> (st_q.active_code == $past(default_code)) && !st_q.defer_en
         && (st_q.buffer_code == $past(default_code)))
      else $error("restart code did not restore defaults");

   AST_INIT: assert property (
      init_load |=> st_q.active_code == (st_q.lvl_sync[1] ? dcu_pkg::CODE_MID
                                                          : dcu_pkg::CODE_ZERO)
         || $changed(st_q.lvl_sync[1]))
      else $error("reset level not applied");

   AST_THERMO: assert property (
      ##1 ($countones(st_q.segments) == 32'($past(st_q.active_code[15:12])))
         && ((st_q.segments & (st_q.segments + 15'h0001)) == 15'h0000))
      else $error("segment decode is not a thermometer of the msbs");

   AST_COUNT_SAT: assert property (
      st_q.edge_cnt <= dcu_pkg::FRAME_BITS)
      else $error("edge count ran past frame length");

   // ----------------------------------------------------------------------
   // assertions: refused frames and register sources
   // ----------------------------------------------------------------------
   // a refused frame must leave code, buffer and mode exactly as they were
   sequence s_regs_held;
      $stable(st_q.active_code) && $stable(st_q.buffer_code) && $stable(st_q.defer_en);
   endsequence

   sequence s_read_frame;
      frame_ok && (st_q.shift[dcu_pkg::RW_BIT] != dcu_pkg::WRITE_FLAG) && !init_load;
   endsequence

   sequence s_unmapped_write;
      wr_commit && !init_load && (wr_addr != dcu_pkg::ADDR_CODE)
         && (wr_addr != dcu_pkg::ADDR_MODE) && (wr_addr != dcu_pkg::ADDR_STROBE);
   endsequence

   sequence s_defer_write;
      s_code_write ##0 st_q.defer_en;
   endsequence

   AST_READ_IGNORED: assert property (
      s_read_frame |=> s_regs_held)
      else $error("read frame changed a register");

   AST_UNMAPPED: assert property (
      s_unmapped_write |=> s_regs_held)
      else $error("write to unmapped address changed a register");

   AST_FRAME_START: assert property (
      sel_fall |=> (st_q.shift == 24'h000000) && (st_q.edge_cnt == 5'h00))
      else $error("frame start did not clear the shift register");

   // serial clock and data are blocked while the frame select is high
   AST_IDLE_BLOCKED: assert property (
      st_q.sel_sync[1] |=> st_q.edge_cnt == 5'h00)
      else $error("bits counted while frame select was high");

   // a falling serial clock inside a frame shifts in the data seen with it
   AST_SHIFT_IN: assert property (
      clk_fall && !sel_fall |=> st_q.shift[0] == $past(st_q.dat_sync[1]))
      else $error("serial data bit not shifted in");

   // a stored trigger would copy the new buffer one cycle after the write
   AST_TRIGGER_CLEARED: assert property (
      s_defer_write ##1 !wr_commit |=> $stable(st_q.active_code))
      else $error("load trigger acted again after its load");

   AST_BUF_SOURCE: assert property (
      $changed(st_q.buffer_code) |->
         ($past(wr_commit) && ($past(wr_addr) == dcu_pkg::ADDR_CODE))
         || $past(init_load) || $past(restart))
      else $error("buffer changed without a code write");

   // immediate writes fill both registers at once, loads copy the buffer
   AST_ACTIVE_SOURCE: assert property (
      $changed(st_q.active_code) |-> st_q.active_code == st_q.buffer_code)
      else $error("active code did not come through the buffer");

   AST_MODE_SOURCE: assert property (
      $changed(st_q.defer_en) |->
         ($past(wr_commit) && ($past(wr_addr) == dcu_pkg::ADDR_MODE))
         || $past(init_load) || $past(restart))
      else $error("mode changed without a mode write");

   // defaults load once per reset; a repeat would undo the host's writes
   AST_INIT_ONCE: assert property (
      st_q.init_cnt == dcu_pkg::INIT_DONE |=> st_q.init_cnt == dcu_pkg::INIT_DONE)
      else $error("default load repeated after reset");

endmodule : dcu_core

/* design/dcu_pkg.sv */
// Purpose: constants, register map and state layout of the converter code update path
// Assumes: 16-bit straight-binary codes, 24-bit serial write frames
// Notes:   shared by dcu_core and dcu_thermo

package dcu_pkg;

   // ----------------------------------------------------------------------
   // widths and frame layout
   // ----------------------------------------------------------------------
   localparam int          CODE_W        = 16;
   localparam int          SEG_W         = 15;
   localparam int          LADDER_W      = 12;
   localparam int          FRAME_W       = 24;
   localparam logic [4:0]  FRAME_BITS    = 5'h18;
   localparam int          RW_BIT        = 23;
   localparam int          ADDR_HI       = 22;
   localparam int          ADDR_LO       = 16;

   // ----------------------------------------------------------------------
   // register map and fields
   // ----------------------------------------------------------------------
   localparam logic [6:0]  ADDR_MODE     = 7'h02;
   localparam logic [6:0]  ADDR_STROBE   = 7'h05;
   localparam logic [6:0]  ADDR_CODE     = 7'h08;
   localparam int          MODE_DEFER_BIT = 0;
   localparam int          STROBE_LOAD_BIT = 4;
   localparam logic [3:0]  RESTART_CODE  = 4'ha;
   localparam logic        WRITE_FLAG    = 1'b0;

   // ----------------------------------------------------------------------
   // reset values
   // ----------------------------------------------------------------------
   localparam logic [15:0] CODE_ZERO     = 16'h0000;
   localparam logic [15:0] CODE_MID      = 16'h8000;
   localparam logic        MODE_RESET    = 1'b0;
   localparam logic [1:0]  INIT_LOAD     = 2'h2;
   localparam logic [1:0]  INIT_DONE     = 2'h3;

   // ----------------------------------------------------------------------
   // timing
   // ----------------------------------------------------------------------
   localparam int          CLK_PERIOD_NS = 10;
   localparam int          UPDATE_SPACING_TIME_NS = 1000;
   localparam int          UPDATE_SPACING_CYC =
      (UPDATE_SPACING_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // ----------------------------------------------------------------------
   // state of the core
   // ----------------------------------------------------------------------
   typedef struct packed {
      logic [1:0]  sel_sync;
      logic [1:0]  clk_sync;
      logic [1:0]  dat_sync;
      logic [1:0]  lvl_sync;
      logic        sel_last;
      logic        clk_last;
      logic [1:0]  init_cnt;
      logic [4:0]  edge_cnt;
      logic [23:0] shift;
      logic [15:0] buffer_code;
      logic [15:0] active_code;
      logic        defer_en;
      logic [14:0] segments;
   } dcu_state_s;

endpackage : dcu_pkg

/* design/dcu_thermo.sv */
// Purpose: thermometer decode of the four code msbs
// Assumes: value 0 turns every segment off, value 15 turns all on
// Notes:   purely combinational, the caller registers the result

`timescale 1ns/1ps

module dcu_thermo (
   // code msbs
   input  wire logic [3:0]  msb,
   // segment controls
   output logic      [14:0] seg
);

   // ----------------------------------------------------------------------
   // one comparator per segment
   // ----------------------------------------------------------------------
   for (genvar i = 0; i < dcu_pkg::SEG_W; i++) begin : g_seg
      localparam logic [3:0] LEVEL = 4'(i + 1);
      assign seg[i] = (msb >= LEVEL);
   end

endmodule : dcu_thermo

/* tb/dcu_core_bench.sv */
// Purpose: self-checking bench for the converter code update path
// Assumes: host model paces frames at least one microsecond apart
// Notes:   table rows cover ordinary frames, resets are hand-written after

`timescale 1ns/1ps

module dcu_core_bench;

   typedef struct {
      logic        strap;
      logic [23:0] frame;
      int          nbits;
      logic [15:0] code;
      logic        defer;
   } dcu_row_s;

   logic        clk;
   logic        reset_n;
   logic        reset_level_select;
   logic        frame_sel_n;
   logic        serial_clk;
   logic        serial_data_in;
   logic [14:0] segment_switch_controls;
   logic [11:0] ladder_switch_controls;
   logic [15:0] active_code;
   logic        defer_mode;
   int          miscompares = 0;
   int          checks_done = 0;
   dcu_row_s    rows [18];

   dcu_core dcu_core_inst (
      .clk                     (clk),
      .reset_n                 (reset_n),
      .frame_sel_n             (frame_sel_n),
      .serial_clk              (serial_clk),
      .serial_data_in          (serial_data_in),
      .reset_level_select      (reset_level_select),
      .segment_switch_controls (segment_switch_controls),
      .ladder_switch_controls  (ladder_switch_controls),
      .active_code             (active_code),
      .defer_mode              (defer_mode)
   );

   dcu_host_model dcu_host_model_inst (
      .frame_sel_n    (frame_sel_n),
      .serial_clk     (serial_clk),
      .serial_data_in (serial_data_in)
   );

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   // ----------------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------------
   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      checks_done++;
      if (seen !== exp) begin
         miscompares++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   function automatic logic [14:0] thermo(input logic [3:0] n);
      logic [15:0] ones;
      ones = (16'h0001 << n) - 16'h0001;
      return ones[14:0];
   endfunction : thermo

   task automatic tick();
      @(posedge clk);
      #1;
   endtask : tick

   // compares every output against one expected code and mode
   task automatic check_all(input logic [15:0] code, input logic defer);
      check("active_code", active_code, code);
      check("ladder", {4'h0, ladder_switch_controls}, {4'h0, code[11:0]});
      check("segments", {1'b0, segment_switch_controls}, {1'b0, thermo(code[15:12])});
      check("defer_mode", {15'h0, defer_mode}, {15'h0, defer});
   endtask : check_all

   task automatic print_verdict();
      $display("checks %0d miscompares %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : print_verdict

   // ----------------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------------
   initial begin
      rows[0]  = '{1'b0, 24'h081234, 24, 16'h1234, 1'b0};
      rows[1]  = '{1'b0, 24'h08ffff, 24, 16'hffff, 1'b0};
      rows[2]  = '{1'b0, 24'h080000, 24, 16'h0000, 1'b0};
      rows[3]  = '{1'b0, 24'h105555, 23, 16'h0000, 1'b0};
      rows[4]  = '{1'b0, 24'h884444, 24, 16'h0000, 1'b0};
      rows[5]  = '{1'b0, 24'h007777, 24, 16'h0000, 1'b0};
      rows[6]  = '{1'b0, 24'h050010, 24, 16'h0000, 1'b0};
      rows[7]  = '{1'b0, 24'h020001, 24, 16'h0000, 1'b1};
      rows[8]  = '{1'b0, 24'h08abcd, 24, 16'h0000, 1'b1};
      rows[9]  = '{1'b0, 24'h200000, 20, 16'h0000, 1'b1};
      rows[10] = '{1'b0, 24'h050010, 24, 16'habcd, 1'b1};
      rows[11] = '{1'b0, 24'h081111, 24, 16'habcd, 1'b1};
      rows[12] = '{1'b0, 24'h020000, 24, 16'habcd, 1'b0};
      rows[13] = '{1'b0, 24'h050010, 24, 16'habcd, 1'b0};
      rows[14] = '{1'b0, 24'h020001, 24, 16'habcd, 1'b1};
      rows[15] = '{1'b0, 24'h050010, 24, 16'h1111, 1'b1};
      rows[16] = '{1'b1, 24'h05000a, 24, 16'h8000, 1'b0};
      rows[17] = '{1'b1, 24'h08f00f, 24, 16'hf00f, 1'b0};
      reset_n            = 1'b0;
      reset_level_select = 1'b0;
      repeat (5) tick();
      reset_n = 1'b1;
      repeat (10) tick();
      check_all(16'h0000, 1'b0);
      foreach (rows[r]) begin
         tick();
         reset_level_select = rows[r].strap;
         dcu_host_model_inst.send(rows[r].frame, rows[r].nbits);
         check_all(rows[r].code, rows[r].defer);
      end
      // deferred mode set, then reset pulled with no clock edge before the look
      tick();
      dcu_host_model_inst.send(24'h020001, 24);
      tick();
      reset_n = 1'b0;
      #2;
      check("async_code", active_code, 16'h0000);
      check("async_defer", {15'h0, defer_mode}, 16'h0000);
      repeat (5) tick();
      reset_n = 1'b1;
      repeat (10) tick();
      check_all(16'h8000, 1'b0);
      print_verdict();
   end

endmodule : dcu_core_bench

/* tb/dcu_host_model.sv */
// Purpose: serial host model that writes 24-bit frames into the code update path
// Assumes: link clock idles high between frames, data shifts on its falling edge
// Notes:   a frame may be cut short on purpose to exercise the discard path

`timescale 1ns/1ps

module dcu_host_model (
   // serial port pins
   output logic frame_sel_n,
   output logic serial_clk,
   output logic serial_data_in
);

   // ----------------------------------------------------------------------
   // link timing
   // ----------------------------------------------------------------------
   // half period of the 125 ns link clock, unrelated in phase to clk
   localparam real HALF_NS = 62.5;

   initial begin
      frame_sel_n    = 1'b1;
      serial_clk     = 1'b1;
      serial_data_in = 1'b0;
   end

   // ----------------------------------------------------------------------
   // frame sender
   // ----------------------------------------------------------------------
   // sends the top nbits of frame msb first; fewer than 24 aborts the write
   task automatic send(input logic [23:0] frame, input int nbits);
      frame_sel_n = 1'b0;
      #100;
      for (int i = 0; i < nbits; i++) begin
         serial_data_in = frame[23-i];
         #(HALF_NS) serial_clk = 1'b0;
         #(HALF_NS) serial_clk = 1'b1;
      end
      #(HALF_NS) frame_sel_n = 1'b1;
      // released data line must not keep showing the last bit
      serial_data_in = ~serial_data_in;
      #1000;
   endtask : send

endmodule : dcu_host_model
